// file: sct_pkg.sv
/*
  Shared constants, types and the strap decode for the serial control target.
  Assumes a 10 MHz reference clock and a separately clocked back-channel link.
*/
package sct_pkg;

  // Register offsets
  localparam logic [7:0] REG_PRIMARY_ADDR = 8'h00;
  localparam logic [7:0] REG_GEN_CONFIG = 8'h02;
  localparam logic [7:0] REG_PORT_SELECT = 8'h4c;
  localparam logic [7:0] REG_BC_CONFIG = 8'h58;
  localparam logic [7:0] REG_REMOTE_ALIAS = 8'h5c;
  localparam logic [7:0] REG_PORT0_ADDR = 8'hf8;
  localparam logic [7:0] REG_PORT1_ADDR = 8'hf9;

  // Field positions
  localparam int PROXY_EN_BIT = 5;
  localparam int PASS_THROUGH_BIT = 6;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam int PSEL_WR_LSB = 0;
  localparam int PSEL_RD_BIT = 4;

  // Rate encodings and reset values
  localparam logic [2:0] RATE_2M5 = 3'h0;
  localparam logic [2:0] RATE_50M = 3'h2;
  localparam logic [7:0] RST_PRIMARY_ADDR = 8'h00;
  localparam logic [7:0] RST_GEN_CONFIG = 8'h00;
  localparam logic [7:0] RST_PORT_SELECT = 8'h01;
  localparam logic [7:0] RST_BC_CONFIG = 8'h00;
  localparam logic [7:0] RST_REMOTE_ALIAS = 8'h00;
  localparam logic [7:0] RST_PORT_ADDR = 8'h00;
  // Capability word sent to the serializer; value is arbitrary
  localparam logic [7:0] CAPABILITIES = 8'h5a;

  // Timing
  localparam int CLK_KHZ = 10000;
  localparam int SCL_MAX_KHZ = 1000;
  localparam int STRAP_WAIT_US = 1000;
  localparam int STRAP_WAIT_CYCLES = (STRAP_WAIT_US * CLK_KHZ + 999) / 1000;

  typedef enum logic [1:0] {
    KIND_START = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_READ = 2'h2,
    KIND_STOP = 2'h3
  } sct_kind_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_REG = 4'h2,
    ST_REG_ACK = 4'h6,
    ST_WDATA = 4'h7,
    ST_WACK = 4'h5,
    ST_RDATA = 4'h4,
    ST_RACK = 4'hc,
    ST_WAIT = 4'hd,
    ST_IGNORE = 4'hf
  } sct_state_e;

  typedef struct packed {
    sct_kind_e kind;
    logic port;
    logic [2:0] rate;
    logic [7:0] data;
  } sct_req_s;

  typedef struct packed {
    sct_req_s req;
    logic [3:0] gpio;
    logic [7:0] caps;
  } sct_frame_s;

  typedef struct packed {
    logic ack;
    logic [7:0] data;
  } sct_rsp_s;

  typedef struct packed {
    logic [7:0] prim;
    logic [7:0] gen;
    logic [7:0] psel;
    logic [1:0][7:0] bcc;
    logic [1:0][7:0] alias_addr;
    logic [7:0] p0;
    logic [7:0] p1;
  } sct_regs_s;

  // Strap band to 7-bit target address
  function automatic logic [6:0] strap_addr(input logic [2:0] band);
    case (band)
      3'h0: strap_addr = 7'h30;
      3'h1: strap_addr = 7'h32;
      3'h2: strap_addr = 7'h34;
      3'h3: strap_addr = 7'h36;
      3'h4: strap_addr = 7'h38;
      3'h5: strap_addr = 7'h3a;
      3'h6: strap_addr = 7'h3c;
      default: strap_addr = 7'h3d;
    endcase
  endfunction

endpackage

// file: sct_sync.sv
/*
  Three-stage input synchroniser; an output bit follows only once stages
  two and three agree. Assumes inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module sct_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous input
  output logic [W-1:0] q // Filtered, synchronised value
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= next_q;
    end
  end
endmodule

// file: sct_target.sv
/*
  Local serial control target with back-channel forwarding.
  Assumes an open-drain bus resolved outside, a host that tolerates clock
  stretching, and a link partner answering every frame once on bc_rx_valid.
*/
`timescale 1ns/1ps
module sct_target #(
  parameter int STRAP_WAIT = sct_pkg::STRAP_WAIT_CYCLES
) (
  input wire logic ref_clk, // Core clock, 10 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic scl_in, // Bus clock level
  output logic scl_out, // Bus clock drive value, always low
  output logic scl_oe, // High while holding bus clock low
  input wire logic sda_in, // Bus data level
  output logic sda_out, // Bus data drive value, always low
  output logic sda_oe, // High while pulling bus data low
  input wire logic power_down_pin_n, // Power-down pin, low powers down
  input wire logic [2:0] address_strap_pin, // Quantised strap band
  input wire logic mode_strap_pin, // Mode strap, high selects fast link
  input wire logic [1:0] rx_lock, // Per-port lock status
  output logic proxy_controller_en, // Proxy controller enable
  output logic [1:0][2:0] back_channel_rate_select, // Per-port link rate
  input wire logic bc_clk, // Link clock
  input wire logic [3:0] gpio_in, // Pin states sent over the link
  output logic bc_tx_valid, // One link-clock pulse per frame
  output sct_pkg::sct_frame_s bc_tx, // Frame to the serializer
  input wire logic bc_rx_valid, // Answer strobe from the link
  input wire sct_pkg::sct_rsp_s bc_rx // Answer from the link
);
  localparam int NS = 10;

  logic [NS-1:0] sync_q;
  logic scl_s, sda_s, pdn_s, mode_s, rsp_tog_s;
  logic [2:0] strap_s;
  logic [1:0] lock_s;

  // Core-domain state
  sct_pkg::sct_state_e state, next_state;
  sct_pkg::sct_state_e after, next_after;
  sct_pkg::sct_regs_s regs, next_regs;
  sct_pkg::sct_req_s req, next_req;
  logic [7:0] shreg, next_shreg;
  logic [7:0] ptr, next_ptr;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [15:0] wait_cnt, next_wait_cnt;
  logic scl_q, sda_q, rw, next_rw, remote, next_remote;
  logic rd_page, next_rd_page, host_ack, next_host_ack;
  logic [1:0] wr_mask, next_wr_mask;
  logic addr_valid, next_addr_valid;
  logic req_tog, next_req_tog, rsp_seen, next_rsp_seen, busy, next_busy;
  logic next_scl_oe, next_sda_oe;

  // Link-domain state
  logic req_tog_s;
  logic [3:0] gpio_s;
  logic req_seen, next_req_seen, rsp_tog, next_rsp_tog;
  logic next_tx_valid;
  sct_pkg::sct_frame_s next_tx;
  sct_pkg::sct_rsp_s rsp, next_rsp;

  logic rise, fall, start, stop, rsp_new;
  logic [7:0] rd_byte;
  logic [6:0] rx_addr;
  logic sel_port, fwd_ok;

  sct_sync #(.W(NS)) u_sync_core (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({scl_in, sda_in, power_down_pin_n, address_strap_pin, mode_strap_pin, rx_lock,
        rsp_tog}),
    .q(sync_q)
  );
  assign {scl_s, sda_s, pdn_s, strap_s, mode_s, lock_s, rsp_tog_s} = sync_q;

  sct_sync #(.W(5)) u_sync_link (
    .clk(bc_clk),
    .rst_n(rst_n),
    .d({req_tog, gpio_in}),
    .q({req_tog_s, gpio_s})
  );

  // Bus events on the filtered levels; oversampling covers 1 MHz bus clocks
  assign rise = scl_s & ~scl_q;
  assign fall = ~scl_s & scl_q;
  assign start = scl_s & scl_q & sda_q & ~sda_s;
  assign stop = scl_s & scl_q & ~sda_q & sda_s;
  assign rsp_new = rsp_tog_s != rsp_seen;
  assign rx_addr = shreg[7:1];
  assign sel_port = regs.psel[sct_pkg::PSEL_RD_BIT];
  // Forwarding needs pass-through on the selected port and its lock
  assign fwd_ok = regs.bcc[sel_port][sct_pkg::PASS_THROUGH_BIT] & lock_s[sel_port];

  function automatic logic [7:0] reg_read(input sct_pkg::sct_regs_s r, input logic [7:0] a,
                                          input logic pg);
    case (a)
      sct_pkg::REG_PRIMARY_ADDR: reg_read = r.prim;
      sct_pkg::REG_GEN_CONFIG: reg_read = r.gen;
      sct_pkg::REG_PORT_SELECT: reg_read = r.psel;
      sct_pkg::REG_BC_CONFIG: reg_read = r.bcc[pg];
      sct_pkg::REG_REMOTE_ALIAS: reg_read = r.alias_addr[pg];
      sct_pkg::REG_PORT0_ADDR: reg_read = r.p0;
      sct_pkg::REG_PORT1_ADDR: reg_read = r.p1;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Byte the pointer addresses, for the next read byte
  assign rd_byte = reg_read(regs, ptr, rd_page);

  always_comb begin
    next_state = state;
    next_after = after;
    next_regs = regs;
    next_req = req;
    next_shreg = shreg;
    next_ptr = ptr;
    next_bit_cnt = bit_cnt;
    next_wait_cnt = wait_cnt;
    next_rw = rw;
    next_remote = remote;
    next_rd_page = rd_page;
    next_wr_mask = wr_mask;
    next_host_ack = host_ack;
    next_addr_valid = addr_valid;
    next_req_tog = req_tog;
    next_rsp_seen = rsp_seen;
    next_busy = busy;
    next_sda_oe = sda_oe;
    next_scl_oe = 1'b0;

    // Strap capture once the power-down pin has been high long enough
    if (!pdn_s) begin
      next_wait_cnt = 16'h0000;
      next_addr_valid = 1'b0;
    end else if (!addr_valid) begin
      if (wait_cnt >= 16'(STRAP_WAIT - 1)) begin
        next_addr_valid = 1'b1;
        next_regs.prim = {sct_pkg::strap_addr(strap_s), 1'b0};
        for (int p = 0; p < 2; p++) begin
          next_regs.bcc[p][sct_pkg::RATE_LSB +: sct_pkg::RATE_W] =
            mode_s ? sct_pkg::RATE_50M : sct_pkg::RATE_2M5;
        end
      end else begin
        next_wait_cnt = wait_cnt + 16'h0001;
      end
    end

    if (rsp_new) begin
      next_rsp_seen = ~rsp_seen;
      next_busy = 1'b0;
    end

    if (start) begin
      // A repeated start while forwarding becomes a fresh remote start
      next_state = sct_pkg::ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop) begin
      next_state = sct_pkg::ST_IDLE;
      next_sda_oe = 1'b0;
      if (remote && !busy) begin
        next_req = '{kind: sct_pkg::KIND_STOP, port: sel_port,
                     rate: regs.bcc[sel_port][2:0], data: 8'h00};
        next_req_tog = ~req_tog;
        next_busy = 1'b1;
      end
      next_remote = 1'b0;
    end else begin
      case (state)
        sct_pkg::ST_IDLE, sct_pkg::ST_IGNORE: begin
          next_sda_oe = 1'b0;
        end
        sct_pkg::ST_ADDR, sct_pkg::ST_REG, sct_pkg::ST_WDATA: begin
          if (rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (fall && bit_cnt == 4'h8) begin
            next_bit_cnt = 4'h0;
            if (state == sct_pkg::ST_ADDR) begin
              next_rw = shreg[0];
              next_remote = 1'b0;
              next_state = sct_pkg::ST_ADDR_ACK;
              next_sda_oe = 1'b1;
              if (addr_valid && rx_addr == regs.prim[7:1]) begin
                next_rd_page = sel_port;
                next_wr_mask = regs.psel[sct_pkg::PSEL_WR_LSB +: 2];
              end else if (regs.p0 != 8'h00 && rx_addr == regs.p0[7:1]) begin
                next_rd_page = 1'b0;
                next_wr_mask = 2'b01;
              end else if (regs.p1 != 8'h00 && rx_addr == regs.p1[7:1]) begin
                next_rd_page = 1'b1;
                next_wr_mask = 2'b10;
              end else if (fwd_ok && regs.alias_addr[sel_port] != 8'h00 &&
                           rx_addr == regs.alias_addr[sel_port][7:1] && !busy) begin
                next_remote = 1'b1;
                next_sda_oe = 1'b0;
                next_req = '{kind: sct_pkg::KIND_START, port: sel_port,
                             rate: regs.bcc[sel_port][2:0], data: shreg};
                next_req_tog = ~req_tog;
                next_busy = 1'b1;
                next_after = sct_pkg::ST_ADDR_ACK;
                next_state = sct_pkg::ST_WAIT;
                next_scl_oe = 1'b1;
              end else begin
                next_sda_oe = 1'b0;
                next_state = sct_pkg::ST_IGNORE;
              end
            end else if (state == sct_pkg::ST_REG && !remote) begin
              next_ptr = shreg;
              next_sda_oe = 1'b1;
              next_state = sct_pkg::ST_REG_ACK;
            end else if (remote) begin
              next_req = '{kind: sct_pkg::KIND_WRITE, port: sel_port,
                           rate: regs.bcc[sel_port][2:0], data: shreg};
              next_req_tog = ~req_tog;
              next_busy = 1'b1;
              next_after = sct_pkg::ST_WACK;
              next_state = sct_pkg::ST_WAIT;
              next_scl_oe = 1'b1;
            end else begin
              case (ptr)
                sct_pkg::REG_PRIMARY_ADDR: next_regs.prim = shreg;
                sct_pkg::REG_GEN_CONFIG: next_regs.gen = shreg;
                sct_pkg::REG_PORT_SELECT: next_regs.psel = shreg;
                sct_pkg::REG_PORT0_ADDR: next_regs.p0 = shreg;
                sct_pkg::REG_PORT1_ADDR: next_regs.p1 = shreg;
                default: begin
                end
              endcase
              for (int p = 0; p < 2; p++) begin
                if (wr_mask[p] && ptr == sct_pkg::REG_BC_CONFIG) begin
                  next_regs.bcc[p] = shreg;
                end
                if (wr_mask[p] && ptr == sct_pkg::REG_REMOTE_ALIAS) begin
                  next_regs.alias_addr[p] = shreg;
                end
              end
              next_ptr = ptr + 8'h01;
              next_sda_oe = 1'b1;
              next_state = sct_pkg::ST_WACK;
            end
          end
        end
        sct_pkg::ST_ADDR_ACK, sct_pkg::ST_REG_ACK, sct_pkg::ST_WACK: begin
          if (fall) begin
            next_sda_oe = 1'b0;
            next_bit_cnt = 4'h0;
            if (state != sct_pkg::ST_ADDR_ACK || !rw) begin
              next_state = (state == sct_pkg::ST_ADDR_ACK && !remote) ?
                           sct_pkg::ST_REG : sct_pkg::ST_WDATA;
            end else if (remote) begin
              next_req = '{kind: sct_pkg::KIND_READ, port: sel_port,
                           rate: regs.bcc[sel_port][2:0], data: 8'h00};
              next_req_tog = ~req_tog;
              next_busy = 1'b1;
              next_after = sct_pkg::ST_RDATA;
              next_state = sct_pkg::ST_WAIT;
              next_scl_oe = 1'b1;
            end else begin
              next_shreg = rd_byte;
              next_sda_oe = ~rd_byte[7];
              next_ptr = ptr + 8'h01;
              next_state = sct_pkg::ST_RDATA;
            end
          end
        end
        sct_pkg::ST_RDATA: begin
          if (fall) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == 4'h7) begin
              next_sda_oe = 1'b0;
              next_state = sct_pkg::ST_RACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6];
            end
          end
        end
        sct_pkg::ST_RACK: begin
          if (rise) begin
            next_host_ack = ~sda_s;
          end else if (fall) begin
            next_bit_cnt = 4'h0;
            if (!host_ack) begin
              next_state = sct_pkg::ST_IGNORE;
            end else if (remote) begin
              next_req = '{kind: sct_pkg::KIND_READ, port: sel_port,
                           rate: regs.bcc[sel_port][2:0], data: 8'h00};
              next_req_tog = ~req_tog;
              next_busy = 1'b1;
              next_after = sct_pkg::ST_RDATA;
              next_state = sct_pkg::ST_WAIT;
              next_scl_oe = 1'b1;
            end else begin
              next_shreg = rd_byte;
              next_sda_oe = ~rd_byte[7];
              next_ptr = ptr + 8'h01;
              next_state = sct_pkg::ST_RDATA;
            end
          end
        end
        sct_pkg::ST_WAIT: begin
          // Data is set up first; the clock is let go on the next cycle
          next_scl_oe = 1'b1;
          if (rsp_new) begin
            next_scl_oe = 1'b1;
            next_state = after;
            if (after == sct_pkg::ST_RDATA) begin
              next_shreg = rsp.data;
              next_sda_oe = ~rsp.data[7];
            end else begin
              next_sda_oe = rsp.ack;
            end
          end
        end
        default: begin
          next_state = sct_pkg::ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= sct_pkg::ST_IDLE;
      after <= sct_pkg::ST_IDLE;
      regs <= '{prim: sct_pkg::RST_PRIMARY_ADDR, gen: sct_pkg::RST_GEN_CONFIG,
                psel: sct_pkg::RST_PORT_SELECT,
                bcc: {sct_pkg::RST_BC_CONFIG, sct_pkg::RST_BC_CONFIG},
                alias_addr: {sct_pkg::RST_REMOTE_ALIAS, sct_pkg::RST_REMOTE_ALIAS},
                p0: sct_pkg::RST_PORT_ADDR, p1: sct_pkg::RST_PORT_ADDR};
      req <= '0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      bit_cnt <= 4'h0;
      wait_cnt <= 16'h0000;
      scl_q <= 1'b0;
      sda_q <= 1'b0;
      rw <= 1'b0;
      remote <= 1'b0;
      rd_page <= 1'b0;
      wr_mask <= 2'b00;
      host_ack <= 1'b0;
      addr_valid <= 1'b0;
      req_tog <= 1'b0;
      rsp_seen <= 1'b0;
      busy <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      proxy_controller_en <= 1'b0;
      back_channel_rate_select <= '0;
    end else begin
      state <= next_state;
      after <= next_after;
      regs <= next_regs;
      req <= next_req;
      shreg <= next_shreg;
      ptr <= next_ptr;
      bit_cnt <= next_bit_cnt;
      wait_cnt <= next_wait_cnt;
      scl_q <= scl_s;
      sda_q <= sda_s;
      rw <= next_rw;
      remote <= next_remote;
      rd_page <= next_rd_page;
      wr_mask <= next_wr_mask;
      host_ack <= next_host_ack;
      addr_valid <= next_addr_valid;
      req_tog <= next_req_tog;
      rsp_seen <= next_rsp_seen;
      busy <= next_busy;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      proxy_controller_en <= next_regs.gen[sct_pkg::PROXY_EN_BIT];
      for (int p = 0; p < 2; p++) begin
        back_channel_rate_select[p] <=
          next_regs.bcc[p][sct_pkg::RATE_LSB +: sct_pkg::RATE_W];
      end
    end
  end

  // Link side: req stays stable while busy, so it is safe to take here
  always_comb begin
    next_req_seen = req_seen;
    next_tx_valid = 1'b0;
    next_tx = bc_tx;
    next_rsp = rsp;
    next_rsp_tog = rsp_tog;
    if (req_tog_s != req_seen) begin
      next_req_seen = ~req_seen;
      next_tx_valid = 1'b1;
      next_tx = '{req: req, gpio: gpio_s, caps: sct_pkg::CAPABILITIES};
    end
    if (bc_rx_valid) begin
      next_rsp = bc_rx;
      next_rsp_tog = ~rsp_tog;
    end
  end

  always_ff @(posedge bc_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen <= 1'b0;
      bc_tx_valid <= 1'b0;
      bc_tx <= '0;
      rsp <= '0;
      rsp_tog <= 1'b0;
    end else begin
      req_seen <= next_req_seen;
      bc_tx_valid <= next_tx_valid;
      bc_tx <= next_tx;
      rsp <= next_rsp;
      rsp_tog <= next_rsp_tog;
    end
  end
endmodule

// file: sct_link_model.sv
/* Far end of the back channel: answers each frame once, after a delay.
   Assumes one-cycle frame strobes on bc_clk. */
`timescale 1ns/1ps
module sct_link_model (
  input logic bc_clk, // Link clock
  input logic rst_n, // Reset, active low
  input logic tx_valid, // Frame strobe
  output logic rx_valid, // Answer strobe
  output sct_pkg::sct_rsp_s rx // Answer
);
  logic [2:0] cnt;
  always @(posedge bc_clk or negedge rst_n) begin
    rx_valid <= 1'b0;
    rx <= sct_pkg::sct_rsp_s'(~rx); // Idle answer churns so stale data never looks valid
    cnt <= (cnt == 3'h0) ? 3'h0 : cnt - 3'h1;
    if (!rst_n) begin
      cnt <= 3'h0;
      rx <= '0;
    end else if (tx_valid) begin
      cnt <= 3'h4; // Slow answer forces a visible stretch
    end else if (cnt == 3'h1) begin
      rx_valid <= 1'b1;
      rx <= sct_pkg::sct_rsp_s'({1'b1, 8'hc3}); // Same ACK and byte for every kind
    end
  end
endmodule

// file: sct_target_properties.sv
/* Port checker for sct_target, bound after the module.
   Assumes rst_n resets both clock domains. */
`timescale 1ns/1ps
module sct_target_properties #(parameter int STRAP_WAIT = sct_pkg::STRAP_WAIT_CYCLES) (
  input logic ref_clk, // Core clock
  input logic rst_n, // Reset
  input logic scl_in, // Bus clock
  input logic scl_oe, // Clock hold
  input logic sda_oe, // Data pull
  input logic power_down_pin_n, // Power-down
  input logic proxy_controller_en, // Proxy enable
  input logic [1:0][2:0] back_channel_rate_select, // Rates
  input logic bc_clk, // Link clock
  input logic bc_tx_valid, // Frame strobe
  input sct_pkg::sct_frame_s bc_tx // Frame
);
  logic [15:0] up, next_up;
  always_comb begin
    next_up = (up == 16'hffff) ? up : up + 16'h1;
    if (!power_down_pin_n)
      next_up = 16'h0;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      up <= 16'h0;
    else
      up <= next_up;
  end
  a_pull_after_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sda_oe |-> up >= STRAP_WAIT) else $error("bus answered too early");
  a_rate_after_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(back_channel_rate_select) |-> up >= STRAP_WAIT) else $error("rate set early");
  a_sda_scl_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(sda_oe) |-> !scl_in) else $error("data moved, clock high");
  a_proxy_scl_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(proxy_controller_en) |-> !scl_in) else $error("proxy moved, clock high");
  a_frame_single: assert property (@(posedge bc_clk) disable iff (!rst_n)
    bc_tx_valid |=> !bc_tx_valid) else $error("frame strobe too long");
  a_frame_caps: assert property (@(posedge bc_clk) disable iff (!rst_n)
    bc_tx_valid |-> bc_tx.caps == sct_pkg::CAPABILITIES) else $error("bad capabilities");
  a_frame_rate: assert property (@(posedge bc_clk) disable iff (!rst_n)
    bc_tx_valid |-> bc_tx.req.rate == back_channel_rate_select[bc_tx.req.port])
    else $error("frame rate wrong");
  a_frame_stretch: assert property (@(posedge bc_clk) disable iff (!rst_n)
    bc_tx_valid && bc_tx.req.kind != sct_pkg::KIND_STOP |-> scl_oe) else $error("no stretch");
  c_read: cover property (@(posedge bc_clk) bc_tx_valid && bc_tx.req.kind == sct_pkg::KIND_READ);
  c_proxy: cover property (@(posedge ref_clk) $rose(proxy_controller_en));
  c_hold: cover property (@(posedge ref_clk) $rose(scl_oe));
endmodule
bind sct_target sct_target_properties #(.STRAP_WAIT(STRAP_WAIT)) u_props (.ref_clk(ref_clk),
  .rst_n(rst_n), .scl_in(scl_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .power_down_pin_n(power_down_pin_n), .proxy_controller_en(proxy_controller_en),
  .back_channel_rate_select(back_channel_rate_select), .bc_clk(bc_clk),
  .bc_tx_valid(bc_tx_valid), .bc_tx(bc_tx));

// file: tb.sv
/* Bench: bit-banged bus host, link model, register and forwarding tests.
   Assumes pull-ups on both bus wires, resolved here. */
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0, bc_clk = 1'b0, rst_n = 1'b0, pd_n = 1'b0, hc = 1'b1, hd = 1'b1;
  logic str = 1'b0, scl_oe, sda_oe, bv, rv, pen;
  logic [1:0][2:0] rate;
  logic [15:0] ks = 16'h0;
  logic [3:0] gs;
  logic [7:0] d;
  logic [7:0] fd;
  logic so, sdo;
  logic [1:0] lk = 2'h3;
  logic [7:0] ro [5] = '{8'h00, 8'h02, 8'h4c, 8'h58, 8'hf9};
  logic [7:0] ev [5] = '{8'h7a, 8'h00, 8'h01, 8'h02, 8'h00};
  int num_errors = 0, tests_run = 0;
  sct_pkg::sct_frame_s bt;
  sct_pkg::sct_rsp_s br;
  wire scl = hc & ~scl_oe;
  wire sda = hd & ~sda_oe;
  always #50 ref_clk = ~ref_clk;
  always #62.5 bc_clk = ~bc_clk;
  sct_target #(.STRAP_WAIT(20)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl),
    .scl_out(so), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sdo), .sda_oe(sda_oe),
    .power_down_pin_n(pd_n), .address_strap_pin(3'h7), .mode_strap_pin(1'b1),
    .rx_lock(lk), .proxy_controller_en(pen), .back_channel_rate_select(rate),
    .bc_clk(bc_clk), .gpio_in(4'h9), .bc_tx_valid(bv), .bc_tx(bt), .bc_rx_valid(rv),
    .bc_rx(br)); // Lock stays high for remote traffic except the port 0 out-of-lock alias test
  sct_link_model lnk (.bc_clk(bc_clk), .rst_n(rst_n), .tx_valid(bv), .rx_valid(rv), .rx(br));
  always @(posedge ref_clk) if (scl_oe) str <= 1'b1;
  always @(posedge bc_clk) if (bv) {ks, gs} <= {ks[13:0], bt.req.kind, bt.gpio};
  always @(posedge bc_clk) if (bv && bt.req.kind == sct_pkg::KIND_WRITE) fd <= bt.req.data;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  task automatic ck(input string s, input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", s, exp, got);
    end
  endtask
  task automatic bit1(input logic b, output logic r);
    int i;
    hd = b;
    cyc(4);
    hc = 1'b1;
    for (i = 0; i < 300 && scl !== 1'b1; i++) cyc(1); // Host waits out stretching
    if (scl !== 1'b1) ck("stretch end", scl, 1'b1);
    cyc(4);
    r = sda;
    hc = 1'b0;
    cyc(4);
  endtask
  task automatic cond(input logic s); // 1 gives start, 0 gives stop
    hd = s;
    cyc(4);
    hc = 1'b1;
    cyc(6);
    hd = !s;
    cyc(20);
    hc = !s;
    cyc(4);
  endtask
  task automatic tx(input logic [7:0] v, output logic a);
    logic r;
    for (int k = 7; k >= 0; k--) bit1(v[k], r);
    bit1(1'b1, r);
    a = !r;
  endtask
  task automatic rx(output logic [7:0] v);
    logic [8:0] t;
    for (int k = 8; k >= 0; k--) bit1(1'b1, t[k]); // Ninth bit is the closing NACK
    v = t[8:1];
  endtask
  task automatic wr(input logic [6:0] dv, input logic [7:0] r, v, input logic ea);
    logic a;
    cond(1'b1);
    tx({dv, 1'b0}, a);
    ck("addr ack", a, ea);
    if (a) begin
      tx(r, a);
      tx(v, a);
      ck("data ack", a, 1'b1);
    end
    cond(1'b0); // Writes always close with stop
  endtask
  task automatic rd(input logic [6:0] dv, input logic [7:0] r, output logic [7:0] v);
    logic a;
    cond(1'b1);
    tx({dv, 1'b0}, a);
    tx(r, a);
    cond(1'b1);
    tx({dv, 1'b1}, a);
    ck("read ack", a, 1'b1);
    rx(v);
    cond(1'b0);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #8000000;
    num_errors++;
    conclude();
  end
  initial begin
    cyc(12);
    rst_n = 1'b1;
    cyc(2);
    pd_n = 1'b1;
    cyc(40);
    foreach (ro[i]) begin
      rd(7'h3d, ro[i], d);
      ck("reset", d, ev[i]);
    end
    ck("rates", rate, {sct_pkg::RATE_50M, sct_pkg::RATE_50M});
    wr(7'h30, 8'h02, 8'h20, 1'b0);
    wr(7'h3d, 8'h02, 8'h20, 1'b1);
    ck("proxy", pen, 1'b1);
    wr(7'h3d, 8'hf8, 8'h60, 1'b1);
    wr(7'h3d, 8'hf9, 8'h64, 1'b1);
    wr(7'h30, 8'h58, 8'h40, 1'b1);
    rd(7'h32, 8'h58, d);
    ck("page1", d, 8'h02);
    rd(7'h30, 8'h58, d);
    ck("page0", d, 8'h40);
    ck("rates", rate, {sct_pkg::RATE_50M, sct_pkg::RATE_2M5});
    rd(7'h32, 8'h02, d);
    ck("shared", d, 8'h20);
    ck("stretch", str, 1'b0);
    wr(7'h30, 8'h5c, 8'ha0, 1'b1); // Port select left at port 0
    ks = 16'h0;
    wr(7'h50, 8'h11, 8'h22, 1'b1);
    ck("wr frames", ks, 16'h0017);
    ck("stretch", str, 1'b1);
    ck("gpio", gs, 4'h9);
    ck("fwd data", fd, 8'h22);
    ck("drive low", {so, sdo}, 2'h0);
    ks = 16'h0;
    rd(7'h50, 8'h11, d);
    ck("remote", d, 8'hc3);
    ck("rd frames", ks, 16'h004b);
    // Port 0 out of lock: the alias must go unanswered
    lk = 2'h2;
    cyc(8);
    wr(7'h50, 8'h11, 8'h22, 1'b0);
    lk = 2'h3;
    cyc(8);
    wr(7'h30, 8'h58, 8'h00, 1'b1);
    wr(7'h50, 8'h11, 8'h22, 1'b0);
    conclude();
  end
endmodule
